// ---- rtl/pacm_params.svh ----
// register offsets, field positions and reset values of the port A pin configuration block
`ifndef PACM_PARAMS_SVH
`define PACM_PARAMS_SVH
`define PACM_ADDR_DATA      16'hf250
`define PACM_ADDR_DIR       16'hf251
`define PACM_ADDR_CFG_LOW   16'hf252
`define PACM_ADDR_CFG_HIGH  16'hf253
`define PACM_ADDR_FUNC      16'hf254
`define PACM_RST_BYTE       8'h00
`define PACM_FUNC_MASK      8'h0f
`define PACM_BIT_SER_RX     0
`define PACM_BIT_SER_CLK    1
`define PACM_BIT_SER_TX     2
`define PACM_BIT_PWM        3
`define PACM_CODE_HIZ       2'h0
`define PACM_CODE_PCH       2'h1
`define PACM_CODE_NCH       2'h2
`define PACM_CODE_CMOS      2'h3
`endif

// ---- rtl/pacm_pkg.sv ----
// types shared by the port A pin configuration block
package pacm_pkg;
   typedef enum logic [1:0] {
      PACM_DRV_HIZ,
      PACM_DRV_PCH,
      PACM_DRV_NCH,
      PACM_DRV_CMOS
   } pacm_drive_e;

   typedef struct packed {
      logic       serial_tx_data;
      logic       serial_clk_out;
      logic       serial_clk_oe;
      logic       pulse_width_out_zero;
   } pacm_periph_s;

   typedef struct packed {
      logic       addr_sel_ok;
      logic [7:0] wdata;
   } pacm_unused_s;
endpackage : pacm_pkg

// ---- rtl/pacm_port_a.sv ----
// port A pin electrical mode selection and secondary function routing
`timescale 1ns/100ps
`include "pacm_params.svh"

// Notes on behaviour
// - output direction code picks hi-z, p-open-drain, n-open-drain or push-pull drive.
// - input direction code picks hi-z, pull-down, pull-up, or hi-z.
// - hi-z output switches off both high and low drivers.
// - direction 0 uses the output meaning, direction 1 the input meaning.
// - control pair byte or word accessible at lower address, resets to zero.
// - function bit 0 routes pin 0 to serial receive data.
// - function bit 1 routes pin 1 to the bidirectional serial clock.
// - function bit 2 routes pin 2 to serial transmit data.
// - function bit 3 routes pin 3 to the first pwm output.
// - function register byte wide, resets zero, upper four bits read zero.
// - output-mode general pin drives its data register bit.
// - input-mode data read returns pin levels; writes stored only.
// - direction bits reset to 0 meaning output; 1 means input.
module pacm_port_a
   import pacm_pkg::*;
#(
   parameter int NPINS = 8
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // special function register bus
   input  wire logic [15:0]        sfr_addr,
   input  wire logic               sfr_wr,
   input  wire logic               sfr_rd,
   input  wire logic               sfr_word,
   input  wire logic [15:0]        sfr_wdata,
   output logic      [15:0]        sfr_rdata,
   // on-chip peripherals
   input  wire pacm_periph_s       periph,
   output logic                    serial_rx_data,
   output logic                    serial_shift_clock_in,
   // pins
   input  wire logic [NPINS-1:0]   pad_in,
   output logic      [NPINS-1:0]   pad_out,
   output logic      [NPINS-1:0]   pad_oe,
   output logic      [NPINS-1:0]   pad_pull_up,
   output logic      [NPINS-1:0]   pad_pull_down
);

   // elaboration stop: the register map has room for eight pins at most
   if (NPINS < 4 || NPINS > 8) begin : g_npins_check
      $error("pacm_port_a: NPINS must be 4 to 8");
   end

   typedef struct packed {
      logic [7:0]  data;
      logic [7:0]  dir;
      logic [15:0] cfg;
      logic [7:0]  func;
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic [15:0] rdata;
      logic [7:0]  out;
      logic [7:0]  oe;
      logic [7:0]  pu;
      logic [7:0]  pd;
      logic        rx;
      logic        sck_in;
   } pacm_state_s;

   pacm_state_s s_q, s_d;

   function automatic logic [7:0] pin_mask();
      return 8'((16'h1 << NPINS) - 16'h1);
   endfunction : pin_mask

   // byte read mux, shared by both halves of a word access
   function automatic logic [7:0] rd_byte(input pacm_state_s s, input logic [15:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         `PACM_ADDR_DATA:     r = ((s.data & ~s.dir) | (s.sync2 & s.dir)) & pin_mask();
         `PACM_ADDR_DIR:      r = s.dir & pin_mask();
         `PACM_ADDR_CFG_LOW:  r = s.cfg[7:0];
         `PACM_ADDR_CFG_HIGH: r = s.cfg[15:8];
         `PACM_ADDR_FUNC:     r = s.func & `PACM_FUNC_MASK;
         default:             r = 8'h00;
      endcase
      return r;
   endfunction : rd_byte

   // electrical controls of one pad
   typedef struct packed {
      logic oe;
      logic pu;
      logic pd;
   } pacm_pad_s;

   // one pin's code read against its direction; used for every pin
   function automatic pacm_pad_s pad_decode(input logic [1:0] c,
                                            input logic       d,
                                            input logic       v);
      pacm_pad_s p;
      p = '0;
      if (!d) begin
         case (pacm_drive_e'(c))
            PACM_DRV_HIZ:  p.oe = 1'b0;
            // open drain: enable follows the value (p-channel) or its inverse (n-channel), so only one rail is ever driven
            PACM_DRV_PCH:  p.oe = v;
            PACM_DRV_NCH:  p.oe = ~v;
            PACM_DRV_CMOS: p.oe = 1'b1;
            default:       p.oe = 1'b0;
         endcase
      end else begin
         // codes 00 and 11 both leave the input floating
         case (c)
            `PACM_CODE_PCH: p.pd = 1'b1;
            `PACM_CODE_NCH: p.pu = 1'b1;
            default:        p.pd = 1'b0;
         endcase
      end
      return p;
   endfunction : pad_decode

   always_comb begin
      logic [15:0] hi_addr;
      logic [7:0]  eff_val;
      logic [7:0]  eff_dir;
      logic [1:0]  code;
      logic [7:0]  rd_lo;
      logic [7:0]  rd_hi;
      pacm_pad_s   pad;
      hi_addr = 16'(sfr_addr + 16'h1);
      eff_val = 8'h00;
      eff_dir = 8'h00;
      code    = 2'h0;
      rd_lo   = 8'h00;
      rd_hi   = 8'h00;
      pad     = '0;
      s_d     = s_q;
      // two flops: pad levels are asynchronous, the first flop may go metastable
      s_d.sync1 = 8'(pad_in);
      s_d.sync2 = s_q.sync1;

      if (sfr_wr) begin
         case (sfr_addr)
            `PACM_ADDR_DATA: s_d.data = sfr_wdata[7:0] & pin_mask();
            `PACM_ADDR_DIR:  s_d.dir  = sfr_wdata[7:0] & pin_mask();
            `PACM_ADDR_CFG_LOW: begin
               s_d.cfg[7:0] = sfr_wdata[7:0];
               if (sfr_word) begin
                  s_d.cfg[15:8] = sfr_wdata[15:8];
               end
            end
            `PACM_ADDR_CFG_HIGH: s_d.cfg[15:8] = sfr_wdata[7:0];
            `PACM_ADDR_FUNC:     s_d.func = sfr_wdata[7:0] & `PACM_FUNC_MASK;
            default: ;
         endcase
      end

      // read data is registered and held until the next read
      rd_lo = rd_byte(s_q, sfr_addr);
      if (sfr_word && sfr_addr == `PACM_ADDR_CFG_LOW) begin
         rd_hi = rd_byte(s_q, hi_addr);
      end
      if (sfr_rd) begin
         s_d.rdata = {rd_hi, rd_lo};
      end

      // value and direction per pin, peripherals overriding the port path
      eff_val = s_q.data;
      eff_dir = s_q.dir;
      if (s_q.func[`PACM_BIT_SER_RX]) begin
         eff_dir[0] = 1'b1;
      end
      if (s_q.func[`PACM_BIT_SER_CLK]) begin
         eff_val[1] = periph.serial_clk_out;
         eff_dir[1] = ~periph.serial_clk_oe;
      end
      if (s_q.func[`PACM_BIT_SER_TX]) begin
         eff_val[2] = periph.serial_tx_data;
         eff_dir[2] = 1'b0;
      end
      if (s_q.func[`PACM_BIT_PWM]) begin
         eff_val[3] = periph.pulse_width_out_zero;
         eff_dir[3] = 1'b0;
      end
      for (int i = 0; i < 8; i++) begin
         code = s_q.cfg[2*i +: 2];
         s_d.out[i] = eff_val[i];
         s_d.oe[i]  = 1'b0;
         s_d.pu[i]  = 1'b0;
         s_d.pd[i]  = 1'b0;
         if (i >= NPINS) begin
            // pins beyond the port stay dark whatever the registers hold
            s_d.out[i] = 1'b0;
         end else begin
            pad       = pad_decode(code, eff_dir[i], eff_val[i]);
            s_d.oe[i] = pad.oe;
            s_d.pu[i] = pad.pu;
            s_d.pd[i] = pad.pd;
         end
      end
      // routed inputs read zero while the pin serves the port
      s_d.rx     = s_q.sync2[0] & s_q.func[`PACM_BIT_SER_RX];
      s_d.sck_in = s_q.sync2[1] & s_q.func[`PACM_BIT_SER_CLK];

      // synchronous reset last, so it overrides every update above
      if (!rst_n) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign sfr_rdata             = s_q.rdata;
   assign serial_rx_data        = s_q.rx;
   assign serial_shift_clock_in = s_q.sck_in;
   assign pad_out               = s_q.out[NPINS-1:0];
   assign pad_oe                = s_q.oe[NPINS-1:0];
   assign pad_pull_up           = s_q.pu[NPINS-1:0];
   assign pad_pull_down         = s_q.pd[NPINS-1:0];

endmodule : pacm_port_a

// ---- dv/pacm_port_a_props.sv ----
// port-level assertions for the port A pin configuration block
`timescale 1ns/100ps
module pacm_port_a_props #(parameter int NPINS = 8) (
   // clock, reset and register bus
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic [15:0]      sfr_addr,
   input wire logic             sfr_rd,
   input wire logic [15:0]      sfr_rdata,
   // pins and routed inputs
   input wire logic             serial_rx_data,
   input wire logic [NPINS-1:0] pad_oe,
   input wire logic [NPINS-1:0] pad_pull_up,
   input wire logic [NPINS-1:0] pad_pull_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_pull_excl: assert property ((pad_pull_up & pad_pull_down) == 0) else $error("two pulls");
   a_pull_drive: assert property ((pad_oe & (pad_pull_up | pad_pull_down)) == 0)
      else $error("pull on driven pin");
   a_reset_quiet: assert property (!$past(rst_n) |-> (pad_oe | pad_pull_up | pad_pull_down) == 0)
      else $error("pin active after reset");
   a_rx_reset: assert property (!$past(rst_n) |-> !serial_rx_data ##1 !serial_rx_data)
      else $error("rx routed after reset");
   a_unmapped_zero: assert property (sfr_rd && (sfr_addr < 16'hf250 || sfr_addr > 16'hf254)
      |=> sfr_rdata == 0) else $error("unmapped read not zero");
   a_func_upper: assert property (sfr_rd && sfr_addr == 16'hf254 |=> sfr_rdata[15:4] == 0)
      else $error("function upper bits set");
   a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("rdata moved");
   a_high_byte: assert property (sfr_rd && sfr_addr != 16'hf252 |=> sfr_rdata[15:8] == 0)
      else $error("high byte not zero");
endmodule : pacm_port_a_props
bind pacm_port_a pacm_port_a_props #(.NPINS(NPINS)) pacm_port_a_props_i (.*);

// ---- dv/pacm_pin_model.sv ----
// board-side pad model: external driver, pull resistors, floating lines
`timescale 1ns/100ps
module pacm_pin_model (
   // block side, then board side
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pull_up,
   input wire logic [7:0] pull_down,
   input wire logic [7:0] ext,
   input wire logic       ext_en,
   output logic     [7:0] pad_in
);
   // a floating pin reads the inverse of the last board level, never a stale copy
   assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_en ? ext : pull_up | ~pull_down & ~ext);
endmodule : pacm_pin_model

// ---- dv/pacm_port_a_tb.sv ----
// self-checking bench for the port A pin configuration block
`timescale 1ns/100ps
module pacm_port_a_tb;
   logic                  clk = 0, rst_n = 0, wr = 0, rd = 0, wd = 0, ee = 0, rx, sck;
   logic [15:0]           ad = 0, wdat = 0, rdat;
   logic [7:0]            po, oe, pu, pd, pin, ext = 0;
   pacm_pkg::pacm_periph_s per = '0;
   int                    error_cnt = 0, tests_run = 0, cyc = 0;
   pacm_port_a pacm_port_a_i (.clk(clk), .rst_n(rst_n), .sfr_addr(ad), .sfr_wr(wr), .sfr_rd(rd),
      .sfr_word(wd), .sfr_wdata(wdat), .sfr_rdata(rdat), .periph(per), .serial_rx_data(rx),
      .serial_shift_clock_in(sck), .pad_in(pin), .pad_out(po), .pad_oe(oe), .pad_pull_up(pu),
      .pad_pull_down(pd));
   pacm_pin_model pacm_pin_model_i (.pad_out(po), .pad_oe(oe), .pull_up(pu), .pull_down(pd),
      .ext(ext), .ext_en(ee), .pad_in(pin));
   initial forever #25 clk = ~clk;
   always @(negedge clk) if (++cyc == 2000) begin
      error_cnt++;
      summarize();
   end
   task automatic chk(logic [15:0] g, e);
      tests_run++;
      error_cnt += int'(g !== e);
      if (g !== e) $display("Error %0t: got %h want %h", $time, g, e);
   endtask : chk
   // one access, then time for the pads to follow; a read compares against d
   task automatic acc(logic [15:0] a, d, logic w, r);
      @(negedge clk) {ad, wdat, wd, wr, rd} = {a, d, w, !r, r};
      @(negedge clk) {wr, rd} = 2'h0;
      repeat (3) @(negedge clk);
      if (r) chk(rdat, d);
   endtask : acc
   task automatic t_out;
      for (int a = 16'hf250; a < 16'hf256; a++) acc(a[15:0], 16'h0, 1'h1, 1'h1);
      chk({oe, pu | pd}, 16'h0);
      acc(16'hf252, 16'hffe4, 1'h1, 1'h0);
      acc(16'hf250, 16'h000f, 1'h0, 1'h0);
      chk({oe, po & oe}, 16'hfa0a);
      acc(16'hf250, 16'h00f0, 1'h0, 1'h0);
      chk({oe, po & oe}, 16'hfcf0);
      acc(16'hf252, 16'hffe4, 1'h1, 1'h1);
   endtask : t_out
   task automatic t_in;
      {ext, ee} = {8'h3c, 1'h1};
      acc(16'hf251, 16'h00ff, 1'h0, 1'h0);
      chk({pu, pd | oe}, 16'h0402);
      acc(16'hf250, 16'h003c, 1'h1, 1'h1);
      acc(16'hf250, 16'h0055, 1'h0, 1'h0);
      chk({oe, pin}, 16'h003c);
      acc(16'hf250, 16'h003c, 1'h1, 1'h1);
   endtask : t_in
   task automatic t_func;
      acc(16'hf254, 16'h00ff, 1'h0, 1'h0);
      acc(16'hf254, 16'h000f, 1'h1, 1'h1);
      {per, ext} = {4'hf, 8'h01};
      acc(16'hf252, 16'hffff, 1'h1, 1'h0);
      chk({po & oe, rx, sck}, 16'h003b);
      {per, ext} = {4'hd, 8'h01};
      repeat (5) @(negedge clk);
      chk({po & oe, rx, sck}, 16'h0032);
      acc(16'hf254, 16'h0, 1'h0, 1'h0);
      chk({po & oe, rx, sck}, 16'h0);
   endtask : t_func
   // mid-run reset from a busy state: registers and pads fall back to zero
   task automatic t_reset;
      acc(16'hf251, 16'h0000, 1'h0, 1'h0);
      chk({oe, po & oe}, 16'hff55);
      acc(16'hf250, 16'h0055, 1'h1, 1'h1);
      rst_n = 1'h0;
      repeat (2) @(negedge clk);
      rst_n = 1'h1;
      chk({oe, pu | pd}, 16'h0);
      chk(rdat, 16'h0);
      chk({rx, sck}, 16'h0);
      for (int a = 16'hf250; a < 16'hf255; a++) acc(a[15:0], 16'h0, 1'h1, 1'h1);
   endtask : t_reset
   task automatic summarize;
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'h1;
      t_out();
      t_in();
      t_func();
      t_reset();
      summarize();
   end
endmodule : pacm_port_a_tb
